/* common/tie_pkg.sv */
// package of constants and types for the threshold and interrupt enable block
package tie_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] TIE_OFS_LIMIT1_HIGH = 8'h52;
	localparam logic [7:0] TIE_OFS_LIMIT1_LOW = 8'h53;
	localparam logic [7:0] TIE_OFS_LIMIT2_HIGH = 8'h54;
	localparam logic [7:0] TIE_OFS_LIMIT2_LOW = 8'h55;
	localparam logic [7:0] TIE_OFS_EN_PRIMARY = 8'h58;
	localparam logic [7:0] TIE_OFS_EN_SECONDARY = 8'h59;
	localparam logic [7:0] TIE_OFS_VARIANT = 8'hFF;

	// ****************************************
	// reset values and writable bit masks
	// ****************************************
	localparam logic [7:0] TIE_RST_HIGH = 8'hFF;
	localparam logic [7:0] TIE_RST_LOW = 8'h00;
	localparam logic [7:0] TIE_RST_EN = 8'h00;
	localparam logic [7:0] TIE_MASK_EN_PRIMARY = 8'hFE;
	localparam logic [7:0] TIE_MASK_EN_SECONDARY = 8'h8F;

	// ****************************************
	// field positions
	// ****************************************
	localparam int TIE_BIT_ALMOST_FULL = 7;
	localparam int TIE_BIT_FRAME_READY = 6;
	localparam int TIE_BIT_DATA_READY = 5;
	localparam int TIE_BIT_AMBIENT_OVF = 4;
	localparam int TIE_BIT_EXPOSURE_OVF = 3;
	localparam int TIE_BIT_LIMIT_TWO = 2;
	localparam int TIE_BIT_LIMIT_ONE = 1;
	localparam int TIE_BIT_INVALID_CFG = 7;
	localparam int TIE_BIT_EMITTER4 = 3;
	localparam int TIE_BIT_EMITTER3 = 2;
	localparam int TIE_BIT_EMITTER2 = 1;
	localparam int TIE_BIT_EMITTER1 = 0;

	// ****************************************
	// threshold scaling and sample counts
	// ****************************************
	localparam int TIE_LIMIT_SHIFT = 11;
	localparam int TIE_CODE_W = 20;
	localparam logic [2:0] TIE_SEL_OFF = 3'h0;
	localparam logic [2:0] TIE_SEL_RESERVED = 3'h7;
	localparam logic [3:0] TIE_CNT_HYST0 = 4'h1;
	localparam logic [3:0] TIE_CNT_HYST1 = 4'h2;
	localparam logic [3:0] TIE_CNT_HYST2 = 4'h4;
	localparam logic [3:0] TIE_CNT_HYST3 = 4'h8;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tie_reg_req_t;

	typedef struct packed {
		logic valid;
		logic [2:0] meas;
		logic [TIE_CODE_W-1:0] code;
	} tie_sample_t;

endpackage

/* core/tie_limit.sv */
// one threshold-crossing detector with consecutive-sample qualification
`timescale 1ns/10ps
module tie_limit #(
	parameter int CODE_W = tie_pkg::TIE_CODE_W
) (
	input wire logic ref_clk, // device clock
	input wire logic rst, // synchronous reset, high
	input wire tie_pkg::tie_sample_t sample, // measurement result stream
	input wire logic [2:0] source_select, // measurement watched, 0 and 7 off
	input wire logic [1:0] sample_count_sel, // consecutive sample code
	input wire logic [7:0] high_code, // upper limit, units of 2048
	input wire logic [7:0] low_code, // lower limit, units of 2048
	output logic cross_set_q // one-cycle crossing event
);

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [1:0] {
		TIE_ST_INSIDE = 2'b01,
		TIE_ST_OUTSIDE = 2'b10
	} tie_lim_state_t;

	typedef struct packed {
		tie_lim_state_t st;
		logic [3:0] run;
		logic set;
	} tie_lim_t;

	tie_lim_t s_q;
	tie_lim_t s_d;
	logic [CODE_W-1:0] low_lim;
	logic [CODE_W-1:0] high_lim;
	logic active;
	logic outside;
	logic [3:0] needed;

	function automatic logic [3:0] run_needed(input logic [1:0] sel);
		case (sel)
			2'h0: run_needed = tie_pkg::TIE_CNT_HYST0;
			2'h1: run_needed = tie_pkg::TIE_CNT_HYST1;
			2'h2: run_needed = tie_pkg::TIE_CNT_HYST2;
			default: run_needed = tie_pkg::TIE_CNT_HYST3;
		endcase
	endfunction

	assign low_lim = CODE_W'({low_code, 11'h000});
	assign high_lim = CODE_W'({high_code, 11'h000});
	assign active = sample.valid && (sample.meas == source_select) &&
		(source_select != tie_pkg::TIE_SEL_OFF) && (source_select != tie_pkg::TIE_SEL_RESERVED);
	// a zero limit field switches that side of the check off
	assign outside = ((low_code != 8'h00) && (sample.code < low_lim)) ||
		((high_code != 8'h00) && (sample.code > high_lim));
	assign needed = run_needed(sample_count_sel);

	always_comb begin
		s_d = s_q;
		s_d.set = 1'b0;
		case (s_q.st)
			TIE_ST_INSIDE: begin
				if (active && outside) begin
					if (s_q.run + 4'h1 >= needed) begin
						s_d.set = 1'b1;
						s_d.st = TIE_ST_OUTSIDE;
						s_d.run = 4'h0;
					end else begin
						s_d.run = s_q.run + 4'h1;
					end
				end else if (active) begin
					s_d.run = 4'h0;
				end
			end
			// one event per excursion; re-armed by a sample back inside the limits
			TIE_ST_OUTSIDE: begin
				if (active && !outside) begin
					s_d.st = TIE_ST_INSIDE;
				end
			end
			default: begin
				s_d.st = TIE_ST_INSIDE;
				s_d.run = 4'h0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_q <= '{st: TIE_ST_INSIDE, run: 4'h0, set: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cross_set_q = s_q.set;

	// ****************************************
	// checks
	// ****************************************
	lower_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		(active && low_code == 8'h00 && (high_code == 8'h00 || sample.code <= high_lim)) |=> !s_q.set)
		else $error("crossing flagged below a disabled lower limit");

	immediate_set_a: assert property (@(posedge ref_clk) disable iff (rst)
		(s_q.st == TIE_ST_INSIDE && active && outside && sample_count_sel == 2'h0) |=> s_q.set)
		else $error("immediate crossing not flagged");

	run_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
		s_q.set |-> $past(s_q.run) + 4'h1 >= $past(needed))
		else $error("crossing flagged before enough samples");

endmodule

/* core/tie_core.sv */
// threshold limit registers, interrupt enables and interrupt pin drive
`timescale 1ns/10ps
module tie_core #(
	parameter logic [7:0] VARIANT_CODE = 8'h5A, // arbitrary identification value
	parameter int CODE_W = tie_pkg::TIE_CODE_W
) (
	input wire logic ref_clk, // device clock
	input wire logic rst, // synchronous reset, high
	input wire tie_pkg::tie_reg_req_t reg_req, // register port request
	output logic [7:0] reg_rdata_q, // read data, valid cycle after rd
	input wire logic [7:0] status_primary, // status flags, first status register
	input wire logic [7:0] status_secondary, // status flags, second status register
	input wire tie_pkg::tie_sample_t sample, // measurement results
	input wire logic [2:0] limit_one_source_select, // measurement for first limit
	input wire logic [2:0] limit_two_source_select, // measurement for second limit
	input wire logic [1:0] consecutive_sample_count, // shared sample qualification
	output logic limit_one_cross_flag, // set pulse for first crossing flag
	output logic limit_two_cross_flag, // set pulse for second crossing flag
	output logic irq_out_n // interrupt pin, active low
);

	// ****************************************
	// register state
	// ****************************************
	typedef struct packed {
		logic [1:0][7:0] high_code;
		logic [1:0][7:0] low_code;
		logic [7:0] en_primary;
		logic [7:0] en_secondary;
		logic [7:0] rdata;
		logic irq_n;
	} tie_core_t;

	tie_core_t r_q;
	tie_core_t r_d;
	logic [1:0] cross_set;
	logic [2:0] src_sel [2];
	logic [7:0] pend_primary;
	logic [7:0] pend_secondary;

	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		hit = (addr == ofs);
	endfunction

	assign src_sel[0] = limit_one_source_select;
	assign src_sel[1] = limit_two_source_select;

	// ****************************************
	// threshold detectors
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_limit
			tie_limit #(
				.CODE_W(CODE_W)
			) u_limit (
				.ref_clk(ref_clk),
				.rst(rst),
				.sample(sample),
				.source_select(src_sel[gi]),
				.sample_count_sel(consecutive_sample_count),
				.high_code(r_q.high_code[gi]),
				.low_code(r_q.low_code[gi]),
				.cross_set_q(cross_set[gi])
			);
		end
	endgenerate

	// the flags themselves stay set in the status register whatever the enables are;
	// only the gated copy reaches the pin
	assign pend_primary = status_primary & r_q.en_primary;
	assign pend_secondary = status_secondary & r_q.en_secondary;

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		r_d = r_q;
		if (reg_req.wr) begin
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_LIMIT1_HIGH)) begin
				r_d.high_code[0] = reg_req.wdata;
			end
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_LIMIT1_LOW)) begin
				r_d.low_code[0] = reg_req.wdata;
			end
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_LIMIT2_HIGH)) begin
				r_d.high_code[1] = reg_req.wdata;
			end
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_LIMIT2_LOW)) begin
				r_d.low_code[1] = reg_req.wdata;
			end
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_EN_PRIMARY)) begin
				r_d.en_primary = reg_req.wdata & tie_pkg::TIE_MASK_EN_PRIMARY;
			end
			if (hit(reg_req.addr, tie_pkg::TIE_OFS_EN_SECONDARY)) begin
				r_d.en_secondary = reg_req.wdata & tie_pkg::TIE_MASK_EN_SECONDARY;
			end
			// identification register has no write path
		end
		if (reg_req.rd) begin
			case (reg_req.addr)
				tie_pkg::TIE_OFS_LIMIT1_HIGH: r_d.rdata = r_q.high_code[0];
				tie_pkg::TIE_OFS_LIMIT1_LOW: r_d.rdata = r_q.low_code[0];
				tie_pkg::TIE_OFS_LIMIT2_HIGH: r_d.rdata = r_q.high_code[1];
				tie_pkg::TIE_OFS_LIMIT2_LOW: r_d.rdata = r_q.low_code[1];
				tie_pkg::TIE_OFS_EN_PRIMARY: r_d.rdata = r_q.en_primary;
				tie_pkg::TIE_OFS_EN_SECONDARY: r_d.rdata = r_q.en_secondary;
				tie_pkg::TIE_OFS_VARIANT: r_d.rdata = VARIANT_CODE;
				default: r_d.rdata = 8'h00;
			endcase
		end
		// routes each enabled flag onto the one active-low pin
		r_d.irq_n = ~(|pend_primary | |pend_secondary);
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			r_q.high_code <= {tie_pkg::TIE_RST_HIGH, tie_pkg::TIE_RST_HIGH};
			r_q.low_code <= {tie_pkg::TIE_RST_LOW, tie_pkg::TIE_RST_LOW};
			r_q.en_primary <= tie_pkg::TIE_RST_EN;
			r_q.en_secondary <= tie_pkg::TIE_RST_EN;
			r_q.rdata <= 8'h00;
			r_q.irq_n <= 1'b1;
		end else begin
			r_q <= r_d;
		end
	end

	assign reg_rdata_q = r_q.rdata;
	assign irq_out_n = r_q.irq_n;
	assign limit_one_cross_flag = cross_set[0];
	assign limit_two_cross_flag = cross_set[1];

	// ****************************************
	// checks
	// ****************************************
	almost_full_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_ALMOST_FULL] && r_q.en_primary[tie_pkg::TIE_BIT_ALMOST_FULL])
		|=> !irq_out_n)
		else $error("almost-full did not raise interrupt");

	frame_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_FRAME_READY] && r_q.en_primary[tie_pkg::TIE_BIT_FRAME_READY])
		|=> !irq_out_n)
		else $error("frame-ready did not raise interrupt");

	data_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_DATA_READY] && r_q.en_primary[tie_pkg::TIE_BIT_DATA_READY])
		|=> !irq_out_n)
		else $error("data-ready did not raise interrupt");

	ambient_ovf_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_AMBIENT_OVF] && r_q.en_primary[tie_pkg::TIE_BIT_AMBIENT_OVF])
		|=> !irq_out_n)
		else $error("ambient overflow did not raise interrupt");

	exposure_ovf_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_EXPOSURE_OVF] && r_q.en_primary[tie_pkg::TIE_BIT_EXPOSURE_OVF])
		|=> !irq_out_n)
		else $error("exposure overflow did not raise interrupt");

	limit_two_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_LIMIT_TWO] && r_q.en_primary[tie_pkg::TIE_BIT_LIMIT_TWO])
		|=> !irq_out_n)
		else $error("second crossing did not raise interrupt");

	limit_one_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_primary[tie_pkg::TIE_BIT_LIMIT_ONE] && r_q.en_primary[tie_pkg::TIE_BIT_LIMIT_ONE])
		|=> !irq_out_n)
		else $error("first crossing did not raise interrupt");

	invalid_cfg_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_secondary[tie_pkg::TIE_BIT_INVALID_CFG] && r_q.en_secondary[tie_pkg::TIE_BIT_INVALID_CFG])
		|=> !irq_out_n)
		else $error("invalid configuration did not raise interrupt");

	emitter_four_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_secondary[tie_pkg::TIE_BIT_EMITTER4] && r_q.en_secondary[tie_pkg::TIE_BIT_EMITTER4])
		|=> !irq_out_n)
		else $error("emitter four did not raise interrupt");

	emitter_three_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_secondary[tie_pkg::TIE_BIT_EMITTER3] && r_q.en_secondary[tie_pkg::TIE_BIT_EMITTER3])
		|=> !irq_out_n)
		else $error("emitter three did not raise interrupt");

	emitter_two_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_secondary[tie_pkg::TIE_BIT_EMITTER2] && r_q.en_secondary[tie_pkg::TIE_BIT_EMITTER2])
		|=> !irq_out_n)
		else $error("emitter two did not raise interrupt");

	emitter_one_a: assert property (@(posedge ref_clk) disable iff (rst)
		(status_secondary[tie_pkg::TIE_BIT_EMITTER1] && r_q.en_secondary[tie_pkg::TIE_BIT_EMITTER1])
		|=> !irq_out_n)
		else $error("emitter one did not raise interrupt");

	masked_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
		(r_q.en_primary == 8'h00 && r_q.en_secondary == 8'h00) |=> irq_out_n)
		else $error("interrupt raised with every enable cleared");

	irq_release_a: assert property (@(posedge ref_clk) disable iff (rst)
		(pend_primary == 8'h00 && pend_secondary == 8'h00) |=> irq_out_n)
		else $error("interrupt held with no enabled flag pending");

	variant_read_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_VARIANT) |=> reg_rdata_q == VARIANT_CODE)
		else $error("identification read returned wrong value");

	unused_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
		(r_q.en_primary[0] == 1'b0) && ((r_q.en_secondary & 8'h70) == 8'h00))
		else $error("unused enable bit became set");

	enable_reset_a: assert property (@(posedge ref_clk)
		$fell(rst) |-> (r_q.en_primary == 8'h00 && r_q.en_secondary == 8'h00 && irq_out_n))
		else $error("enables not cleared by reset");

	// ****************************************
	// register port checks
	// ****************************************
	// a read in the cycle of a write to the same address returns the old value
	low_one_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_LIMIT1_LOW)
		|=> r_q.low_code[0] == $past(reg_req.wdata))
		else $error("first lower limit write lost");

	low_two_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_LIMIT2_LOW)
		|=> r_q.low_code[1] == $past(reg_req.wdata))
		else $error("second lower limit write lost");

	high_one_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_LIMIT1_HIGH)
		|=> r_q.high_code[0] == $past(reg_req.wdata))
		else $error("first upper limit write lost");

	high_two_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_LIMIT2_HIGH)
		|=> r_q.high_code[1] == $past(reg_req.wdata))
		else $error("second upper limit write lost");

	low_one_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_LIMIT1_LOW)
		|=> reg_rdata_q == $past(r_q.low_code[0]))
		else $error("first lower limit read back wrong");

	low_two_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_LIMIT2_LOW)
		|=> reg_rdata_q == $past(r_q.low_code[1]))
		else $error("second lower limit read back wrong");

	high_one_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_LIMIT1_HIGH)
		|=> reg_rdata_q == $past(r_q.high_code[0]))
		else $error("first upper limit read back wrong");

	high_two_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_LIMIT2_HIGH)
		|=> reg_rdata_q == $past(r_q.high_code[1]))
		else $error("second upper limit read back wrong");

	en_primary_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_EN_PRIMARY)
		|=> r_q.en_primary == ($past(reg_req.wdata) & tie_pkg::TIE_MASK_EN_PRIMARY))
		else $error("primary enable write not masked");

	en_secondary_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_EN_SECONDARY)
		|=> r_q.en_secondary == ($past(reg_req.wdata) & tie_pkg::TIE_MASK_EN_SECONDARY))
		else $error("secondary enable write not masked");

	en_primary_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_EN_PRIMARY)
		|=> reg_rdata_q == $past(r_q.en_primary))
		else $error("primary enable read back wrong");

	en_secondary_rd_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_EN_SECONDARY)
		|=> reg_rdata_q == $past(r_q.en_secondary))
		else $error("secondary enable read back wrong");

	variant_write_a: assert property (@(posedge ref_clk) disable iff (rst)
		(reg_req.wr && reg_req.addr == tie_pkg::TIE_OFS_VARIANT)
		|=> ($stable(r_q.high_code) && $stable(r_q.low_code) && $stable(r_q.en_primary) && $stable(r_q.en_secondary)))
		else $error("write to identification changed a register");

	rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!reg_req.rd
		|=> $stable(reg_rdata_q))
		else $error("read data changed without a read");

	irq_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!irq_out_n && (pend_primary != 8'h00 || pend_secondary != 8'h00))
		|=> !irq_out_n)
		else $error("interrupt released while an enabled flag is pending");

	irq_seen_c: cover property (@(posedge ref_clk) disable iff (rst) $fell(irq_out_n));
	irq_cleared_c: cover property (@(posedge ref_clk) disable iff (rst) $rose(irq_out_n));
	crossing_c: cover property (@(posedge ref_clk) disable iff (rst) limit_one_cross_flag);
	variant_c: cover property (@(posedge ref_clk) disable iff (rst)
		reg_req.rd && reg_req.addr == tie_pkg::TIE_OFS_VARIANT);
	secondary_irq_c: cover property (@(posedge ref_clk) disable iff (rst)
		pend_secondary != 8'h00);

endmodule

/* dv/tie_host_model.sv */
// host model: drives the strobe register port with single-byte writes and reads
`timescale 1ns/10ps
module tie_host_model (
	input wire logic ref_clk, // device clock
	output tie_pkg::tie_reg_req_t reg_req, // register port request
	input wire logic [7:0] reg_rdata_q // read data from the device
);
	// ****************************************
	// register port cycles
	// ****************************************
	initial begin
		reg_req = '0;
	end

	// idle address and data are inverted so a stale value never passes for a live one
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge ref_clk);
		reg_req.wr = 1'b1;
		reg_req.addr = addr;
		reg_req.wdata = data;
		@(negedge ref_clk);
		reg_req.wr = 1'b0;
		reg_req.addr = ~addr;
		reg_req.wdata = ~data;
	endtask

	// read data is taken a full cycle after the strobe, where it is settled and held
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge ref_clk);
		reg_req.rd = 1'b1;
		reg_req.addr = addr;
		@(negedge ref_clk);
		reg_req.rd = 1'b0;
		reg_req.addr = ~addr;
		@(negedge ref_clk);
		data = reg_rdata_q;
	endtask

	// callers only hand an upper limit above the lower one
	task automatic set_limits(input logic [7:0] ofs_high, input logic [7:0] high, input logic [7:0] low);
		write_reg(ofs_high, high);
		write_reg(ofs_high + 8'h01, low);
	endtask
endmodule

/* dv/threshold_interrupt_enable_tb.sv */
// self-checking bench for the threshold limits, interrupt enables and interrupt pin
`timescale 1ns/10ps
module threshold_interrupt_enable_tb;
	localparam logic [7:0] VARIANT = 8'h3C; // arbitrary identification value
	localparam int SRC_BIT [12] = '{7, 6, 5, 4, 3, 2, 1, 7, 3, 2, 1, 0};
	localparam logic [7:0] RST_OFS [7] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h58, 8'h59, 8'h60};
	localparam logic [7:0] RST_VAL [7] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
	logic ref_clk;
	logic rst;
	tie_pkg::tie_reg_req_t reg_req;
	logic [7:0] reg_rdata_q;
	logic [7:0] status_primary;
	logic [7:0] status_secondary;
	tie_pkg::tie_sample_t sample;
	logic [2:0] sel_one;
	logic [2:0] sel_two;
	logic [1:0] count_sel;
	logic cross_one;
	logic cross_two;
	logic irq_out_n;
	logic [7:0] rd;
	int failures;
	int checked;
	int cycles;

	tie_core #(.VARIANT_CODE(VARIANT)) u_dut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
		.reg_rdata_q(reg_rdata_q), .status_primary(status_primary), .status_secondary(status_secondary),
		.sample(sample), .limit_one_source_select(sel_one), .limit_two_source_select(sel_two),
		.consecutive_sample_count(count_sel), .limit_one_cross_flag(cross_one),
		.limit_two_cross_flag(cross_two), .irq_out_n(irq_out_n));
	tie_host_model u_host (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask

	task automatic final_report();
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// one result; its crossing pulse stands only in the cycle after the sampling edge
	task automatic send_sample(input logic [2:0] meas, input logic [19:0] code, input logic e1, input logic e2);
		@(negedge ref_clk);
		sample = '{1'b1, meas, code};
		@(negedge ref_clk);
		check({7'h00, cross_one}, {7'h00, e1});
		check({7'h00, cross_two}, {7'h00, e2});
		sample = '{1'b0, ~meas, ~code};
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic test_reset_regs();
		check({7'h00, irq_out_n}, 8'h01);
		for (int i = 0; i < 7; i++) begin
			u_host.read_reg(RST_OFS[i], rd);
			check(rd, RST_VAL[i]);
		end
	endtask

	task automatic test_variant();
		u_host.read_reg(8'hFF, rd);
		check(rd, VARIANT);
		u_host.write_reg(8'hFF, ~VARIANT);
		u_host.write_reg(8'h60, 8'hA5);
		u_host.read_reg(8'hFF, rd);
		check(rd, VARIANT);
		u_host.read_reg(8'h60, rd);
		check(rd, 8'h00);
	endtask

	task automatic test_enable_mask();
		u_host.write_reg(8'h58, 8'hFF);
		u_host.write_reg(8'h59, 8'hFF);
		u_host.read_reg(8'h58, rd);
		check(rd, 8'hFE);
		u_host.read_reg(8'h59, rd);
		check(rd, 8'h8F);
		u_host.write_reg(8'h58, 8'h00);
		u_host.write_reg(8'h59, 8'h00);
	endtask

	// every other enable in the same register set must not let this flag through; only its own enable does
	task automatic test_routing();
		logic [7:0] ofs;
		logic [7:0] one;
		logic [7:0] mask;
		for (int i = 0; i < 12; i++) begin
			ofs = (i < 7) ? 8'h58 : 8'h59;
			mask = (i < 7) ? 8'hFE : 8'h8F;
			one = 8'h01 << SRC_BIT[i];
			u_host.write_reg(ofs, mask & ~one);
			status_primary = (i < 7) ? one : 8'h00;
			status_secondary = (i < 7) ? 8'h00 : one;
			repeat (2) @(negedge ref_clk);
			check({7'h00, irq_out_n}, 8'h01);
			u_host.write_reg(ofs, one);
			repeat (2) @(negedge ref_clk);
			check({7'h00, irq_out_n}, 8'h00);
			status_primary = 8'h00;
			status_secondary = 8'h00;
			repeat (2) @(negedge ref_clk);
			check({7'h00, irq_out_n}, 8'h01);
			u_host.write_reg(ofs, 8'h00);
		end
	endtask

	task automatic test_lower_limit();
		sel_two = 3'h2;
		u_host.set_limits(8'h54, 8'hFF, 8'h01);
		send_sample(3'h2, 20'd4096, 1'b0, 1'b0);
		send_sample(3'h2, 20'd2048, 1'b0, 1'b0);
		send_sample(3'h2, 20'd2047, 1'b0, 1'b1);
		send_sample(3'h2, 20'd4096, 1'b0, 1'b0);
		u_host.set_limits(8'h54, 8'hFF, 8'h00);
		send_sample(3'h2, 20'd0, 1'b0, 1'b0);
		send_sample(3'h2, 20'd522241, 1'b0, 1'b1);
		sel_two = 3'h0;
	endtask

	// a run of n outside samples fires once at the last, then stays quiet
	task automatic test_counts();
		int n;
		sel_one = 3'h1;
		u_host.set_limits(8'h52, 8'hFF, 8'h01);
		for (int c = 0; c < 4; c++) begin
			count_sel = c[1:0];
			n = 1 << c;
			send_sample(3'h1, 20'd4096, 1'b0, 1'b0);
			for (int k = 1; k <= n; k++) begin
				send_sample(3'h1, 20'd100, k == n, 1'b0);
			end
			send_sample(3'h1, 20'd100, 1'b0, 1'b0);
		end
		// reserved select and a foreign measurement must both be ignored
		count_sel = 2'h0;
		send_sample(3'h1, 20'd4096, 1'b0, 1'b0);
		sel_one = 3'h7;
		send_sample(3'h7, 20'd100, 1'b0, 1'b0);
		sel_one = 3'h1;
		send_sample(3'h2, 20'd100, 1'b0, 1'b0);
		send_sample(3'h1, 20'd100, 1'b1, 1'b0);
		sel_one = 3'h0;
	endtask

	// ****************************************
	// clock, timeout and main sequence
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures = failures + 1;
			final_report();
		end
	end

	initial begin
		failures = 0;
		checked = 0;
		cycles = 0;
		rst = 1'b1;
		status_primary = 8'h00;
		status_secondary = 8'h00;
		sample = '0;
		sel_one = 3'h0;
		sel_two = 3'h0;
		count_sel = 2'h0;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		rst = 1'b0;
		test_reset_regs();
		test_variant();
		test_enable_mask();
		test_routing();
		test_lower_limit();
		test_counts();
		final_report();
	end
endmodule
